// File: sil_pkg.sv
// Package: register map, field layout and carriers for status/interrupt block
package sil_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int LIVE_W = 10;
    localparam int NUM_IN = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_STATUS_A = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_B = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_STICKY   = 7'h02;
    localparam logic [ADDR_W-1:0] ADDR_MASK     = 7'h03;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL  = 7'h04;

    // Sticky / mask bit positions
    localparam int BIT_INPUT_LOSS = 0;
    localparam int BIT_JIT_UNLOCK = 4;
    localparam int BIT_SYN_UNLOCK = 5;
    localparam int BIT_HOLD_ENTRY = 6;
    localparam int BIT_INPUT_LOST = 7;

    // Control field positions
    localparam int CTL_BYPASS  = 0;
    localparam int CTL_MODE_LO = 1;
    localparam int CTL_SEL_LO  = 3;

    // Selection modes
    localparam logic [1:0] MODE_MANUAL     = 2'h0;
    localparam logic [1:0] MODE_SHORT_HOLD = 2'h1;
    localparam logic [1:0] MODE_AUTO_HOLD  = 2'h2;
    localparam logic [1:0] MODE_AUTO       = 2'h3;

    // Reset values
    localparam logic [DATA_W-1:0] RST_STICKY = 8'h00;
    localparam logic [DATA_W-1:0] RST_MASK   = 8'h00;
    localparam logic [DATA_W-1:0] RST_DATA   = 8'h00;

    typedef struct packed {
        logic [NUM_IN-1:0] input_active_now;
        logic              jitter_pll_locked_now;
        logic              synth_pll_locked_now;
        logic              not_in_holdover_now;
        logic              vco_cal_pending;
        logic [1:0]        active_input_code;
    } sil_live_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } sil_bus_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic o;
    } sil_sync_s;

    typedef struct packed {
        logic [DATA_W-1:0] sticky;
        logic [DATA_W-1:0] mask;
        logic              first_pll_bypass;
        logic [1:0]        select_mode;
        logic [1:0]        manual_select;
        logic              irq;
        logic              lock;
        logic [DATA_W-1:0] rdata;
    } sil_state_s;

endpackage

// File: sil_status_irq.sv
// Status collection, sticky flags, interrupt and lock reporting

// How it works
// - Momentary status reads return the present condition, nothing stored
// - Sticky bit sets on its condition, stays until software writes one
// - Write-one clear works only when the condition is gone
// - Each sticky bit has its own enable; disabled bits never reach interrupt
// - With all enables zero the interrupt never asserts
// - Interrupt asserts when any enabled sticky bit is set
// - Interrupt releases only after all enabled sticky bits clear
// - Provide input, lock, holdover, calibration, selection status flags
// - Manual modes: reference valid follows the manually selected input
// - Auto-holdover: invalid when lost in holdover or none; auto: none
// - Lock output high only while synthesizer PLL and, unless bypassed, first PLL report locked
// - Bypassed first PLL is ignored; synthesizer lock alone decides
module sil_status_irq (
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    input  wire sil_pkg::sil_live_s            live_status,
    input  wire logic [sil_pkg::ADDR_W-1:0]    addr,
    input  wire logic [sil_pkg::DATA_W-1:0]    wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [sil_pkg::DATA_W-1:0]    rdata,
    output logic                               irq_out_n,
    output logic                               lock_out
);

    sil_pkg::sil_state_s               st;
    sil_pkg::sil_state_s               next_st;
    sil_pkg::sil_live_s                live;
    sil_pkg::sil_bus_s                 bus;
    logic [sil_pkg::LIVE_W-1:0]        live_bits;
    logic                              pll_input_valid_now;
    logic                              sel_lost;
    logic                              none_valid;
    logic [sil_pkg::DATA_W-1:0]        cond;
    logic [sil_pkg::DATA_W-1:0]        clr;
    logic [sil_pkg::DATA_W-1:0]        status_a;
    logic [sil_pkg::DATA_W-1:0]        status_b;
    logic [sil_pkg::DATA_W-1:0]        control;

    sil_sync #(
        .W (sil_pkg::LIVE_W)
    ) u_sync (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .async_in (live_status),
        .sync_out (live_bits)
    );

    assign live = live_bits;
    assign bus  = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // Reference-valid flag per selection mode
    always_comb begin
        none_valid = (live.input_active_now == '0);
        sel_lost   = !live.input_active_now[live.active_input_code];
        case (st.select_mode)
            sil_pkg::MODE_MANUAL,
            sil_pkg::MODE_SHORT_HOLD: begin
                pll_input_valid_now =
                    live.input_active_now[st.manual_select];
            end
            sil_pkg::MODE_AUTO_HOLD: begin
                pll_input_valid_now = !((sel_lost
                    && !live.not_in_holdover_now) || none_valid);
            end
            sil_pkg::MODE_AUTO: begin
                pll_input_valid_now = !none_valid;
            end
            default: begin
                pll_input_valid_now = 1'b0;
            end
        endcase
    end

    // Fault conditions that set sticky bits
    always_comb begin
        cond = '0;
        cond[sil_pkg::BIT_INPUT_LOSS +: sil_pkg::NUM_IN] =
            ~live.input_active_now;
        cond[sil_pkg::BIT_JIT_UNLOCK] = !live.jitter_pll_locked_now;
        cond[sil_pkg::BIT_SYN_UNLOCK] = !live.synth_pll_locked_now;
        cond[sil_pkg::BIT_HOLD_ENTRY] = !live.not_in_holdover_now;
        cond[sil_pkg::BIT_INPUT_LOST] = !pll_input_valid_now;
    end

    // Momentary status views and control register readback
    always_comb begin
        status_a = {live.vco_cal_pending, live.not_in_holdover_now,
                    live.synth_pll_locked_now, live.jitter_pll_locked_now,
                    live.input_active_now};
        status_b = '0;
        status_b[1:0] = live.active_input_code;
        status_b[2]   = pll_input_valid_now;
        control = '0;
        control[sil_pkg::CTL_BYPASS]       = st.first_pll_bypass;
        control[sil_pkg::CTL_MODE_LO +: 2] = st.select_mode;
        control[sil_pkg::CTL_SEL_LO +: 2]  = st.manual_select;
    end

    assign clr = (bus.wr && bus.addr == sil_pkg::ADDR_STICKY) ?
                 bus.wdata : '0;

    always_comb begin
        next_st = st;
        // Condition set wins over a simultaneous clear
        next_st.sticky = (st.sticky & ~clr) | cond;
        if (bus.wr) begin
            case (bus.addr)
                sil_pkg::ADDR_MASK: begin
                    next_st.mask = bus.wdata;
                end
                sil_pkg::ADDR_CONTROL: begin
                    next_st.first_pll_bypass =
                        bus.wdata[sil_pkg::CTL_BYPASS];
                    next_st.select_mode =
                        bus.wdata[sil_pkg::CTL_MODE_LO +: 2];
                    next_st.manual_select =
                        bus.wdata[sil_pkg::CTL_SEL_LO +: 2];
                end
                default: begin
                end
            endcase
        end
        next_st.irq = |(next_st.sticky & next_st.mask);
        next_st.lock = live.synth_pll_locked_now
            && (st.first_pll_bypass
                || live.jitter_pll_locked_now);
        next_st.rdata = sil_pkg::RST_DATA;
        if (bus.rd) begin
            case (bus.addr)
                sil_pkg::ADDR_STATUS_A: next_st.rdata = status_a;
                sil_pkg::ADDR_STATUS_B: next_st.rdata = status_b;
                sil_pkg::ADDR_STICKY:   next_st.rdata = st.sticky;
                sil_pkg::ADDR_MASK:     next_st.rdata = st.mask;
                sil_pkg::ADDR_CONTROL:  next_st.rdata = control;
                default:                next_st.rdata = sil_pkg::RST_DATA;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st        <= '0;
            st.sticky <= sil_pkg::RST_STICKY;
            st.mask   <= sil_pkg::RST_MASK;
        end else begin
            st <= next_st;
        end
    end

    assign rdata     = st.rdata;
    assign irq_out_n = !st.irq;
    assign lock_out  = st.lock;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    logic sticky_wr;
    assign sticky_wr = bus.wr && bus.addr == sil_pkg::ADDR_STICKY;

    irq_all_masked_a: assert property (
        (st.mask == '0) |-> irq_out_n)
        else $error("Interrupt asserted with all enables zero");

    irq_masked_bit_a: assert property (
        ((st.sticky & st.mask) == '0) |-> irq_out_n)
        else $error("Masked sticky bit reached interrupt");

    irq_pending_low_a: assert property (
        (|(st.sticky & st.mask)) |-> !irq_out_n)
        else $error("Enabled sticky bit set but interrupt high");

    irq_release_clean_a: assert property (
        $rose(irq_out_n) |-> ((st.sticky & st.mask) == '0))
        else $error("Interrupt released with enabled source pending");

    sticky_hold_a: assert property (
        !sticky_wr |=> ((st.sticky & $past(st.sticky)) == $past(st.sticky)))
        else $error("Sticky bit dropped without a clear write");

    sticky_reset_cond_a: assert property (
        rst_b |=> ((st.sticky & $past(cond)) == $past(cond)))
        else $error("Sticky bit not set while condition persists");

    sticky_clear_gone_a: assert property (
        sticky_wr |=> ((st.sticky & $past(bus.wdata) & ~$past(cond)) == '0))
        else $error("Write-one did not clear a gone condition");

    zero_write_keep_a: assert property (
        (sticky_wr && bus.wdata == '0) |=>
            ((st.sticky & $past(st.sticky)) == $past(st.sticky)))
        else $error("Zero write altered sticky bits");

    lock_pin_rule_a: assert property (
        1'b1 |=> (lock_out == ($past(live.synth_pll_locked_now)
            && ($past(st.first_pll_bypass)
                || $past(live.jitter_pll_locked_now)))))
        else $error("Lock output does not follow PLL lock states");

    status_read_now_a: assert property (
        (bus.rd && bus.addr == sil_pkg::ADDR_STATUS_A) |=>
            (rdata == $past(status_a)) ##1 (rdata == '0 || $past(bus.rd)))
        else $error("Momentary read returned stale or held value");

    ref_auto_none_a: assert property (
        (st.select_mode == sil_pkg::MODE_AUTO) |->
            (pll_input_valid_now == (live.input_active_now != '0)))
        else $error("Automatic mode reference-valid wrong");

    ref_manual_sel_a: assert property (
        (st.select_mode == sil_pkg::MODE_MANUAL) |->
            (pll_input_valid_now ==
             live.input_active_now[st.manual_select]))
        else $error("Manual mode reference-valid wrong");

    ref_short_hold_a: assert property (
        (st.select_mode == sil_pkg::MODE_SHORT_HOLD) |->
            (pll_input_valid_now ==
             live.input_active_now[st.manual_select]))
        else $error("Short-term holdover mode reference-valid wrong");

    ref_hold_ok_a: assert property (
        (st.select_mode == sil_pkg::MODE_AUTO_HOLD
            && live.not_in_holdover_now
            && live.input_active_now != '0) |-> pll_input_valid_now)
        else $error("Auto-holdover mode flagged a valid reference lost");

    ref_hold_none_a: assert property (
        (st.select_mode == sil_pkg::MODE_AUTO_HOLD
            && live.input_active_now == '0) |-> !pll_input_valid_now)
        else $error("Auto-holdover mode valid with no active input");

    mask_write_a: assert property (
        (bus.wr && bus.addr == sil_pkg::ADDR_MASK) |=>
            (st.mask == $past(bus.wdata)))
        else $error("Enable register did not take written value");

    ctl_write_a: assert property (
        (bus.wr && bus.addr == sil_pkg::ADDR_CONTROL) |=>
            (st.first_pll_bypass == $past(bus.wdata[sil_pkg::CTL_BYPASS])))
        else $error("Bypass bit did not take written value");

    lock_bypass_a: assert property (
        (st.first_pll_bypass && live.synth_pll_locked_now) |=> lock_out)
        else $error("Bypassed first PLL still blocked lock output");

    lock_synth_drop_a: assert property (
        !live.synth_pll_locked_now |=> !lock_out)
        else $error("Lock output high with synthesizer unlocked");

    lock_jit_drop_a: assert property (
        (!st.first_pll_bypass && !live.jitter_pll_locked_now) |=> !lock_out)
        else $error("Lock output high with first PLL unlocked");

    irq_follow_a: assert property (
        ((cond & st.mask) != '0
            && !(bus.wr && bus.addr == sil_pkg::ADDR_MASK)) |=> !irq_out_n)
        else $error("Present enabled condition did not assert interrupt");

    read_idle_zero_a: assert property (
        !bus.rd |=> (rdata == sil_pkg::RST_DATA))
        else $error("Read data not zero outside a read answer");

    status_a_live_a: assert property (
        (bus.rd && bus.addr == sil_pkg::ADDR_STATUS_A) |=>
            (rdata[sil_pkg::NUM_IN-1:0] == $past(live.input_active_now)))
        else $error("Momentary input flags read wrong");

    status_a_lock_a: assert property (
        (bus.rd && bus.addr == sil_pkg::ADDR_STATUS_A) |=>
            (rdata[sil_pkg::NUM_IN] == $past(live.jitter_pll_locked_now)))
        else $error("Momentary lock flag read wrong");

    status_b_code_a: assert property (
        (bus.rd && bus.addr == sil_pkg::ADDR_STATUS_B) |=>
            (rdata[1:0] == $past(live.active_input_code)))
        else $error("Selected input code read wrong");

    sticky_read_a: assert property (
        (bus.rd && bus.addr == sil_pkg::ADDR_STICKY) |=>
            (rdata == $past(st.sticky)))
        else $error("Sticky read returned wrong value");

    status_wr_ignored_a: assert property (
        (bus.wr && bus.addr == sil_pkg::ADDR_STATUS_A) |=>
            ($stable(st.mask) && $stable(st.first_pll_bypass)))
        else $error("Write to momentary status changed a register");

    irq_fire_c: cover property ($fell(irq_out_n));
    irq_clear_c: cover property (sticky_wr ##1 $rose(irq_out_n));
    lock_gain_c: cover property ($rose(lock_out));
    bypass_lock_c: cover property (st.first_pll_bypass && lock_out
                                   && !live.jitter_pll_locked_now);
    ref_hold_lost_c: cover property (
        st.select_mode == sil_pkg::MODE_AUTO_HOLD && !pll_input_valid_now);

endmodule

// File: sil_status_irq_tb_top.sv
// Self-checking bench for the status, interrupt and lock block
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end end

module sil_status_irq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                         mclk;
    logic                         rst_b;
    sil_pkg::sil_live_s           live;
    logic [sil_pkg::ADDR_W-1:0]   addr;
    logic [sil_pkg::DATA_W-1:0]   wdata;
    logic                         wr;
    logic                         rd;
    logic [sil_pkg::DATA_W-1:0]   rdata;
    logic                         irq_out_n;
    logic                         lock_out;
    logic [7:0]                   rv;
    int                           err_total;
    int                           comparisons;

    sil_status_irq uut (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .live_status (live),
        .addr        (addr),
        .wdata       (wdata),
        .wr          (wr),
        .rd          (rd),
        .rdata       (rdata),
        .irq_out_n   (irq_out_n),
        .lock_out    (lock_out)
    );

    always #4 mclk = ~mclk;

    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Lets synchronised live values reach sticky, irq and lock
    task automatic settle;
        repeat (8) @(posedge mclk);
        #1;
    endtask

    task automatic put_live(input logic [3:0] act, input logic jit,
                            input logic syn, input logic noth);
        @(posedge mclk);
        live.input_active_now      <= act;
        live.jitter_pll_locked_now <= jit;
        live.synth_pll_locked_now  <= syn;
        live.not_in_holdover_now   <= noth;
        settle();
    endtask

    task automatic ref_case(input logic [7:0] ctl, input logic [3:0] act,
                            input logic noth, input logic exp);
        wr_reg(sil_pkg::ADDR_CONTROL, ctl);
        put_live(act, 1'b1, 1'b1, noth);
        rd_reg(sil_pkg::ADDR_STATUS_B, rv);
        `CHK(rv, {5'h00, exp, 2'h2})
    endtask

    task automatic close_out;
        $display("err_total=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100us;
        err_total++;
        close_out();
    end

    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        err_total = 0;
        comparisons = 0;
        live = '{4'hf, 1'b1, 1'b1, 1'b1, 1'b0, 2'h2};
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        settle();
        // Faults seen at reset stay latched, mask zero keeps irq off
        rd_reg(sil_pkg::ADDR_STICKY, rv);
        `CHK(rv, 8'hff)
        `CHK(irq_out_n, 1'b1)
        rd_reg(sil_pkg::ADDR_MASK, rv);
        `CHK(rv, 8'h00)
        rd_reg(sil_pkg::ADDR_STATUS_A, rv);
        `CHK(rv, 8'h7f)
        rd_reg(sil_pkg::ADDR_STATUS_B, rv);
        `CHK(rv, 8'h06)
        @(posedge mclk);
        live.vco_cal_pending <= 1'b1;
        settle();
        rd_reg(sil_pkg::ADDR_STATUS_A, rv);
        `CHK(rv, 8'hff)
        // Zero write keeps bits, one write clears gone conditions
        wr_reg(sil_pkg::ADDR_STICKY, 8'h00);
        rd_reg(sil_pkg::ADDR_STICKY, rv);
        `CHK(rv, 8'hff)
        wr_reg(sil_pkg::ADDR_STICKY, 8'hff);
        rd_reg(sil_pkg::ADDR_STICKY, rv);
        `CHK(rv, 8'h00)
        wr_reg(sil_pkg::ADDR_MASK, 8'hff);
        rd_reg(sil_pkg::ADDR_MASK, rv);
        `CHK(rv, 8'hff)
        `CHK(irq_out_n, 1'b1)
        put_live(4'hd, 1'b1, 1'b1, 1'b1);
        `CHK(irq_out_n, 1'b0)
        wr_reg(sil_pkg::ADDR_STICKY, 8'hff);
        rd_reg(sil_pkg::ADDR_STICKY, rv);
        `CHK(rv, 8'h02)
        `CHK(irq_out_n, 1'b0)
        put_live(4'hf, 1'b1, 1'b1, 1'b1);
        `CHK(irq_out_n, 1'b0)
        wr_reg(sil_pkg::ADDR_STICKY, 8'h02);
        #1;
        `CHK(irq_out_n, 1'b1)
        // Disabled source latches but leaves irq released
        wr_reg(sil_pkg::ADDR_MASK, 8'hfd);
        put_live(4'hd, 1'b1, 1'b1, 1'b1);
        rd_reg(sil_pkg::ADDR_STICKY, rv);
        `CHK(rv, 8'h02)
        `CHK(irq_out_n, 1'b1)
        wr_reg(sil_pkg::ADDR_MASK, 8'h00);
        #1;
        `CHK(irq_out_n, 1'b1)
        put_live(4'h0, 1'b0, 1'b0, 1'b0);
        rd_reg(sil_pkg::ADDR_STICKY, rv);
        `CHK(rv, 8'hff)
        `CHK(irq_out_n, 1'b1)
        // Lock output for every lock pair, without and with bypass
        for (int i = 0; i < 8; i++) begin
            wr_reg(sil_pkg::ADDR_CONTROL, {7'h00, i[2]});
            put_live(4'hf, i[1], i[0], 1'b1);
            `CHK(lock_out, i[0] & (i[1] | i[2]))
        end
        // Reference-valid in each selection mode
        ref_case(8'h10, 4'hb, 1'b1, 1'b0);
        ref_case(8'h0a, 4'hb, 1'b1, 1'b1);
        ref_case(8'h04, 4'hb, 1'b0, 1'b0);
        ref_case(8'h04, 4'hb, 1'b1, 1'b1);
        ref_case(8'h04, 4'h0, 1'b1, 1'b0);
        ref_case(8'h06, 4'hb, 1'b0, 1'b1);
        ref_case(8'h06, 4'h0, 1'b1, 1'b0);
        rd_reg(sil_pkg::ADDR_CONTROL, rv);
        `CHK(rv, 8'h06)
        wr_reg(sil_pkg::ADDR_STATUS_A, 8'hff);
        rd_reg(sil_pkg::ADDR_CONTROL, rv);
        `CHK(rv, 8'h06)
        @(posedge mclk);
        live.active_input_code <= 2'h1;
        settle();
        rd_reg(sil_pkg::ADDR_STATUS_B, rv);
        `CHK(rv, 8'h01)
        rd_reg(7'h05, rv);
        `CHK(rv, 8'h00)
        // Reset in mid-run clears settings and relatches faults
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        settle();
        rd_reg(sil_pkg::ADDR_CONTROL, rv);
        `CHK(rv, 8'h00)
        rd_reg(sil_pkg::ADDR_MASK, rv);
        `CHK(rv, 8'h00)
        rd_reg(sil_pkg::ADDR_STICKY, rv);
        `CHK(rv, 8'hff)
        `CHK(irq_out_n, 1'b1)
        `CHK(lock_out, 1'b1)
        close_out();
    end
endmodule

// File: sil_sync.sv
// Three-stage input synchroniser with agreement filter, one per bit
module sil_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            sil_pkg::sil_sync_s st;
            sil_pkg::sil_sync_s next_st;

            always_comb begin
                next_st    = st;
                next_st.s1 = async_in[i];
                next_st.s2 = st.s1;
                next_st.s3 = st.s2;
                // Accept a change only once stages two and three agree
                if (st.s2 == st.s3) begin
                    next_st.o = st.s3;
                end
            end

            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    st <= '0;
                end else begin
                    st <= next_st;
                end
            end

            assign sync_out[i] = st.o;
        end
    endgenerate

endmodule
